// file: hdl/pcg_bridge.v
// ============================================================
// Purpose : turns cpu i/o and memory requests into bus cycles,
//           including configuration cycles via the two i/o ports
// Assumes : one clock (the bus clock), targets claim by their own decode
// Notes   : outputs all registered; bus pins split into in/out/enable
`timescale 1ns/1ps
`include "pcg_map.vh"

// Notes on behaviour
// - bus is 33 MHz, address and data share the same 32 lines.
// - one address phase of one clock, then one or more data phases, each held until trdy; each later burst phase here follows an idle clock with irdy high.
// - memory burst sends one address; later phases carry data only.
// - address phase command names i/o, memory, configuration or special class.
// - each burst phase moves one dword; implied address rises by four.
// - select port at 0CF8h, read/write, answers only 32-bit accesses.
// - data port at 0CFCh, read/write, 8/16/32-bit, carries config data.
// - select bits 30..24 reserved; writes ignored, reads give zero.
// - select bits 23..16 hold target bus number.
// - select bits 15..11 hold device number.
// - select bits 10..8 function number, passed onto address lines.
// - select bits 7..2 register index, appears unchanged on address lines.
// - select bits 1..0: 00 type 0 cycle, 01 type 1 cycle.
// - type 0 cycle addresses a device on this bus.
// - type 1 cycle addresses downstream bus named by bits 23..16.
// - type 0 decodes device number to exactly one line of 31..11; devices 21..31 drive no line here.
module pcg_bridge
(
    input  wire        sys_clk_i,
    input  wire        rst_n_i,
    // cpu request port
    input  wire        req_i,
    input  wire        req_mem_i,
    input  wire        req_wr_i,
    input  wire [31:0] req_addr_i,
    input  wire [1:0]  req_size_i,
    input  wire [3:0]  req_len_i,
    input  wire [31:0] req_wdata_i,
    output reg         busy_o,
    output reg         phase_ack_o,
    output reg         done_o,
    output reg         err_o,
    output reg  [31:0] rdata_o,
    // shared address/data lines
    input  wire [31:0] ad_i,
    output reg  [31:0] ad_o,
    output reg         ad_oe_o,
    output reg  [3:0]  cbe_n_o,
    output reg         cbe_oe_o,
    output reg         frame_n_o,
    output reg         irdy_n_o,
    output reg         ctl_oe_o,
    input  wire        trdy_n_i,
    input  wire        devsel_n_i,
    input  wire        stop_n_i
);

    // ============================================================
    // one-hot states
    localparam S_IDLE = 5'b00001;
    localparam S_ADDR = 5'b00010;
    localparam S_DATA = 5'b00100;
    localparam S_GAP  = 5'b01000;
    localparam S_TURN = 5'b10000;

    reg  [4:0]  state;
    reg  [31:0] cfg_target_select;
    reg         cyc_wr;
    reg  [3:0]  len_left;
    reg  [29:0] cur_dword;
    reg  [2:0]  claim_cnt;
    reg  [3:0]  phase_be;
    reg  [3:0]  next_be;
    reg  [3:0]  next_cmd;
    reg  [31:0] next_addr;

    wire [31:0] cfg_addr;
    wire [13:0] port_idx;
    wire        hit_sel;
    wire        hit_data;
    wire        cfg_on;
    wire        xfer;
    wire        last_phase;
    wire        claim_lost;
    wire        target_end;

    // ============================================================
    // configuration address word from the select register
    pcg_cfg_addr u_cfg_addr
    (
        .sel_i  (cfg_target_select),
        .addr_o (cfg_addr)
    );

    // ============================================================
    // i/o port decode
    assign port_idx = req_addr_i[`PCG_PORT_IDX_MSB:`PCG_PORT_IDX_LSB];
    assign hit_sel  = !req_mem_i
                      && (port_idx == `PCG_SEL_PORT >> `PCG_PORT_IDX_LSB)
                      && (req_size_i == `PCG_SIZE_32)
                      && (req_addr_i[1:0] == 2'h0);
    assign hit_data = !req_mem_i
                      && (port_idx == `PCG_DATA_PORT >> `PCG_PORT_IDX_LSB);
    assign cfg_on   = cfg_target_select[`PCG_SEL_EN_BIT];

    // ============================================================
    // byte enables from offset and size of the access
    always @*
    begin
        next_be = 4'h0;
        case (req_size_i)
            `PCG_SIZE_8:
            begin
                next_be = 4'h1 << req_addr_i[1:0];
            end
            `PCG_SIZE_16:
            begin
                next_be = req_addr_i[1] ? 4'hC : 4'h3;
            end
            default:
            begin
                next_be = 4'hF;
            end
        endcase
    end

    // ============================================================
    // cycle class and address for the coming address phase
    always @*
    begin
        next_addr = req_addr_i;
        next_cmd  = req_wr_i ? `PCG_CMD_IO_WR : `PCG_CMD_IO_RD;
        if (req_mem_i)
        begin
            // dword address, low bits 00 ask for linear order
            next_addr = {req_addr_i[31:2], 2'h0};
            next_cmd  = req_wr_i ? `PCG_CMD_MEM_WR : `PCG_CMD_MEM_RD;
        end
        else if (hit_data && cfg_on)
        begin
            next_addr = cfg_addr;
            next_cmd  = req_wr_i ? `PCG_CMD_CFG_WR : `PCG_CMD_CFG_RD;
        end
        // otherwise a plain i/o cycle on the full byte address
    end

    // ============================================================
    // bus handshake terms
    assign xfer       = (state == S_DATA) && !irdy_n_o && !trdy_n_i;
    assign last_phase = (len_left == `PCG_LEN_ZERO);
    assign claim_lost = (state == S_DATA) && devsel_n_i
                        && (claim_cnt == `PCG_DEVSEL_TO);
    assign target_end = (state == S_DATA) && !stop_n_i && !devsel_n_i;

    // ============================================================
    // sequencer: address phase, data phases, turnaround
    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state             <= S_IDLE;
            cfg_target_select <= `PCG_SEL_RESET;
            cyc_wr            <= 1'b0;
            len_left          <= 4'h0;
            cur_dword         <= 30'h0;
            claim_cnt         <= 3'h0;
            phase_be          <= 4'h0;
            busy_o            <= 1'b0;
            phase_ack_o       <= 1'b0;
            done_o            <= 1'b0;
            err_o             <= 1'b0;
            rdata_o           <= 32'h0;
            ad_o              <= 32'h0;
            ad_oe_o           <= 1'b0;
            cbe_n_o           <= 4'hF;
            cbe_oe_o          <= 1'b0;
            frame_n_o         <= 1'b1;
            irdy_n_o          <= 1'b1;
            ctl_oe_o          <= 1'b0;
        end
        else
        begin
            phase_ack_o <= 1'b0;
            done_o      <= 1'b0;
            case (state)
                S_IDLE:
                begin
                    if (req_i && hit_sel)
                    begin
                        // local register, no bus cycle
                        if (req_wr_i)
                        begin
                            cfg_target_select <= req_wdata_i & ~`PCG_SEL_RSV_MASK;
                        end
                        rdata_o <= cfg_target_select & ~`PCG_SEL_RSV_MASK;
                        err_o   <= 1'b0;
                        done_o  <= 1'b1;
                    end
                    else if (req_i)
                    begin
                        // address phase: address and command on the lines
                        state     <= S_ADDR;
                        busy_o    <= 1'b1;
                        cyc_wr    <= req_wr_i;
                        ad_o      <= next_addr;
                        ad_oe_o   <= 1'b1;
                        cbe_n_o   <= next_cmd;
                        cbe_oe_o  <= 1'b1;
                        frame_n_o <= 1'b0;
                        ctl_oe_o  <= 1'b1;
                        phase_be  <= next_be;
                        len_left  <= req_mem_i ? req_len_i : `PCG_LEN_ZERO;
                        cur_dword <= next_addr[31:2];
                    end
                end
                S_ADDR:
                begin
                    // first data phase; reads release the shared lines
                    state     <= S_DATA;
                    claim_cnt <= 3'h0;
                    ad_o      <= req_wdata_i;
                    ad_oe_o   <= cyc_wr;
                    cbe_n_o   <= ~phase_be;
                    irdy_n_o  <= 1'b0;
                    frame_n_o <= last_phase;
                end
                S_DATA:
                begin
                    if (devsel_n_i && claim_cnt != `PCG_DEVSEL_TO)
                    begin
                        claim_cnt <= claim_cnt + 3'h1;
                    end
                    if (xfer)
                    begin
                        if (!cyc_wr)
                        begin
                            rdata_o <= ad_i;
                        end
                        phase_ack_o <= 1'b1;
                        err_o       <= 1'b0;
                        if (last_phase || !stop_n_i)
                        begin
                            state     <= S_TURN;
                            frame_n_o <= 1'b1;
                            irdy_n_o  <= 1'b1;
                            ad_oe_o   <= 1'b0;
                        end
                        else
                        begin
                            // next dword, no new address on the lines
                            state     <= S_GAP;
                            irdy_n_o  <= 1'b1;
                            len_left  <= len_left - 4'h1;
                            cur_dword <= cur_dword + `PCG_DWORD_STEP;
                        end
                    end
                    else if (claim_lost || target_end)
                    begin
                        // nobody claimed, or target stopped without data
                        state     <= S_TURN;
                        frame_n_o <= 1'b1;
                        irdy_n_o  <= 1'b1;
                        ad_oe_o   <= 1'b0;
                        err_o     <= 1'b1;
                        if (claim_lost && !cyc_wr)
                        begin
                            rdata_o <= `PCG_ALL_ONES;
                        end
                    end
                end
                S_GAP:
                begin
                    // next burst word loaded, all four lanes
                    state     <= S_DATA;
                    ad_o      <= req_wdata_i;
                    cbe_n_o   <= 4'h0;
                    irdy_n_o  <= 1'b0;
                    frame_n_o <= last_phase;
                end
                S_TURN:
                begin
                    // release lines, finish request
                    state    <= S_IDLE;
                    cbe_oe_o <= 1'b0;
                    cbe_n_o  <= 4'hF;
                    ctl_oe_o <= 1'b0;
                    busy_o   <= 1'b0;
                    done_o   <= 1'b1;
                end
                default:
                begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

endmodule // pcg_bridge

// file: hdl/pcg_map.vh
// ============================================================
// Purpose : constants for the configuration cycle generator
// Assumes : byte-addressed cpu i/o space, 32-bit multiplexed bus
// Notes   : definitions only, no logic
`ifndef PCG_MAP_VH
`define PCG_MAP_VH

// ============================================================
// i/o port addresses (dword index = byte address >> 2)
`define PCG_SEL_PORT        16'h0CF8
`define PCG_DATA_PORT       16'h0CFC
`define PCG_PORT_IDX_MSB    15
`define PCG_PORT_IDX_LSB    2

// ============================================================
// target select register fields
`define PCG_SEL_EN_BIT      31
`define PCG_SEL_RSV_MASK    32'h7F000000
`define PCG_SEL_RESET       32'h00000000
`define PCG_BUS_MSB         23
`define PCG_BUS_LSB         16
`define PCG_DEV_MSB         15
`define PCG_DEV_LSB         11
`define PCG_FUNC_MSB        10
`define PCG_FUNC_LSB        8
`define PCG_IDX_MSB         7
`define PCG_IDX_LSB         2
`define PCG_TYPE_MSB        1
`define PCG_TYPE_LSB        0
`define PCG_TYPE0           2'h0
`define PCG_TYPE1           2'h1
`define PCG_IDSEL_BASE      11
`define PCG_IDSEL_MAX_DEV   5'h14

// ============================================================
// access sizes on the cpu port
`define PCG_SIZE_8          2'h0
`define PCG_SIZE_16         2'h1
`define PCG_SIZE_32         2'h2

// ============================================================
// bus commands driven on the byte-enable lines in the address phase
`define PCG_CMD_IO_RD       4'h2
`define PCG_CMD_IO_WR       4'h3
`define PCG_CMD_MEM_RD      4'h6
`define PCG_CMD_MEM_WR      4'h7
`define PCG_CMD_CFG_RD      4'hA
`define PCG_CMD_CFG_WR      4'hB

// ============================================================
// timing: bus clock, dword step, claim timeout
`define PCG_BUS_MHZ         33
`define PCG_DWORD_STEP      30'h00000001
`define PCG_DEVSEL_TO       3'h5
`define PCG_ALL_ONES        32'hFFFFFFFF
`define PCG_LEN_ZERO        4'h0

`endif

// file: hdl/pcg_cfg_addr.v
// ============================================================
// Purpose : forms the address-phase word of a configuration cycle
// Assumes : select register value is already latched
// Notes   : combinational; type 0 decodes devices 0..20 to one idsel line, 21..31 to none
`timescale 1ns/1ps
`include "pcg_map.vh"

module pcg_cfg_addr
(
    input  wire [31:0] sel_i,
    output reg  [31:0] addr_o
);

    wire [4:0] dev_num;
    wire [5:0] idsel_pos;
    integer    bit_n;

    assign dev_num   = sel_i[`PCG_DEV_MSB:`PCG_DEV_LSB];
    assign idsel_pos = {1'b0, dev_num} + 6'd`PCG_IDSEL_BASE;

    // ============================================================
    // address word for type 0 or type 1
    always @*
    begin
        addr_o = 32'h00000000;
        if (sel_i[`PCG_TYPE_MSB:`PCG_TYPE_LSB] == `PCG_TYPE1)
        begin
            // bus, device, function, index carried through, type bits 01
            addr_o = {8'h00, sel_i[23:2], `PCG_TYPE1};
        end
        else
        begin
            // function and index pass unchanged, type bits 00
            addr_o[`PCG_FUNC_MSB:`PCG_FUNC_LSB] = sel_i[`PCG_FUNC_MSB:`PCG_FUNC_LSB];
            addr_o[`PCG_IDX_MSB:`PCG_IDX_LSB]   = sel_i[`PCG_IDX_MSB:`PCG_IDX_LSB];
            // one upper line high as chip select, none past line 31
            for (bit_n = `PCG_IDSEL_BASE; bit_n < 32; bit_n = bit_n + 1)
            begin
                if (idsel_pos == bit_n[5:0])
                begin
                    addr_o[bit_n] = 1'b1;
                end
            end
        end
    end

endmodule // pcg_cfg_addr

// file: tb/pcg_bridge_chk.sv
// Purpose : port checks for the configuration cycle generator
// Assumes : one clock, async active-low reset
// Notes   : keeps its own copy of the select register
`timescale 1ns/1ps
`include "pcg_map.vh"

// ============================================================
// checker
module pcg_bridge_chk
(
    input logic        sys_clk_i,
    input logic        rst_n_i,
    input logic        req_i,
    input logic        req_mem_i,
    input logic        req_wr_i,
    input logic [31:0] req_addr_i,
    input logic [1:0]  req_size_i,
    input logic [3:0]  req_len_i,
    input logic [31:0] req_wdata_i,
    input logic        busy_o,
    input logic        phase_ack_o,
    input logic        done_o,
    input logic        err_o,
    input logic [31:0] rdata_o,
    input logic [31:0] ad_i,
    input logic [31:0] ad_o,
    input logic        ad_oe_o,
    input logic [3:0]  cbe_n_o,
    input logic        cbe_oe_o,
    input logic        frame_n_o,
    input logic        irdy_n_o,
    input logic        ctl_oe_o,
    input logic        trdy_n_i,
    input logic        devsel_n_i,
    input logic        stop_n_i
);
    logic [31:0] sel_q;
    logic [31:0] t0_addr;
    logic [3:0]  cmd_q;
    logic [3:0]  be_n_q;
    logic [3:0]  be;
    logic        acc;
    logic        sel_hit;
    logic        xfer;

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    // request decode, byte enables and expected type 0 word
    assign acc     = req_i && !busy_o;
    assign sel_hit = acc && !req_mem_i && req_addr_i[15:0] == `PCG_SEL_PORT && req_size_i == `PCG_SIZE_32;
    assign be      = (req_mem_i && req_len_i != 4'h0) || req_size_i == `PCG_SIZE_32 ? 4'hF
                   : (req_size_i == `PCG_SIZE_8 ? 4'h1 : 4'h3) << req_addr_i[1:0];
    assign xfer    = !irdy_n_o && !trdy_n_i && ctl_oe_o;
    assign t0_addr = (sel_q[15:11] <= `PCG_IDSEL_MAX_DEV ? 32'h1 << (sel_q[15:11] + `PCG_IDSEL_BASE) : 32'h0)
                   | {21'h0, sel_q[10:2], 2'b00};

    // copy of select register, command and enables of the taken request
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sel_q  <= `PCG_SEL_RESET;
            cmd_q  <= 4'h0;
            be_n_q <= 4'hF;
        end
        else if (acc)
        begin
            if (sel_hit && req_wr_i)
                sel_q <= req_wdata_i & ~`PCG_SEL_RSV_MASK;
            cmd_q  <= {req_mem_i ? 3'h3 : {req_addr_i[15:2], 2'b00} == `PCG_DATA_PORT && sel_q[31] ? 3'h5 : 3'h1, req_wr_i};
            be_n_q <= ~be;
        end
    end

    a_sel_answer: assert property (sel_hit |=> done_o && !err_o && rdata_o == $past(sel_q))
        else $error("select register answer wrong");
    a_cmd_class: assert property (acc && !sel_hit |=> !frame_n_o && ad_oe_o && cbe_oe_o && cbe_n_o == cmd_q)
        else $error("address phase command wrong");
    a_one_addr: assert property ($fell(frame_n_o) |-> $rose(busy_o))
        else $error("second address phase in one request");
    a_type0_idsel: assert property ($fell(frame_n_o) && cbe_n_o[3:1] == 3'h5 && sel_q[1:0] != `PCG_TYPE1 |->
        ad_o == t0_addr) else $error("type 0 address wrong");
    a_type1_addr: assert property ($fell(frame_n_o) && cbe_n_o[3:1] == 3'h5 && sel_q[1:0] == `PCG_TYPE1 |->
        ad_o == {8'h0, sel_q[23:2], 2'b01}) else $error("type 1 address wrong");
    a_mem_align: assert property ($fell(frame_n_o) && cbe_n_o[3:1] == 3'h3 |-> ad_o[1:0] == 2'b00)
        else $error("memory address not dword aligned");
    a_first_data: assert property ($fell(frame_n_o) |=> !irdy_n_o && cbe_n_o == be_n_q)
        else $error("first data phase enables wrong");
    a_phase_ack: assert property (xfer |=> phase_ack_o && irdy_n_o)
        else $error("data phase not acknowledged");
    a_last_done: assert property (xfer && frame_n_o |=> ##1 done_o && !err_o && !busy_o)
        else $error("no completion after last phase");
    a_burst_gap: assert property (xfer && !frame_n_o |=> ##1 !irdy_n_o)
        else $error("burst did not resume");
endmodule // pcg_bridge_chk

bind pcg_bridge pcg_bridge_chk pcg_bridge_chk_i (.sys_clk_i, .rst_n_i, .req_i, .req_mem_i, .req_wr_i, .req_addr_i,
    .req_size_i, .req_len_i, .req_wdata_i, .busy_o, .phase_ack_o, .done_o, .err_o, .rdata_o, .ad_i, .ad_o, .ad_oe_o,
    .cbe_n_o, .cbe_oe_o, .frame_n_o, .irdy_n_o, .ctl_oe_o, .trdy_n_i, .devsel_n_i, .stop_n_i);

// file: tb/pcg_tgt_model.sv
// Purpose : target on the shared bus, answers fast or slow, or never claims
// Assumes : read data is the decoded address mixed with a fixed pattern
// Notes   : released lines show the inverse of their last value
`timescale 1ns/1ps

// ============================================================
// target model
module pcg_tgt_model
(
    input  logic        clk_i,
    input  logic        rst_n_i,
    input  logic        slow_i,
    input  logic        abort_i,
    input  logic [31:0] ad_o_i,
    input  logic        ad_oe_i,
    input  logic [3:0]  cbe_n_i,
    input  logic        frame_n_i,
    input  logic        irdy_n_i,
    output logic [31:0] bus_o,
    output logic        trdy_n_o,
    output logic        devsel_n_o,
    output logic        stop_n_o,
    output int          n_addr_o
);
    logic [31:0] base;
    logic [31:0] last;
    logic [3:0]  cmd;
    logic [1:0]  wcnt;
    logic        sel;
    logic        busy;
    int          beat;

    // resolved bus level and target control lines
    assign bus_o      = ad_oe_i ? ad_o_i : sel && !cmd[0] ? (base + 32'(beat * 4)) ^ 32'hA5A50000 : ~last;
    assign trdy_n_o   = !(sel && wcnt == 2'h0);
    assign devsel_n_o = !sel;
    assign stop_n_o   = 1'b1;

    // claim every address phase unless abort is set, count beats, release after last phase or abort
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            {sel, busy, wcnt, cmd} <= 8'h0;
            {beat, n_addr_o, last} <= 96'h0;
        end
        else
        begin
            last <= bus_o;
            if (!frame_n_i && !busy)
            begin
                busy     <= 1'b1;
                sel      <= !abort_i;
                base     <= bus_o;
                cmd      <= cbe_n_i;
                beat     <= 0;
                wcnt     <= slow_i ? 2'h2 : 2'h0;
                n_addr_o <= n_addr_o + 1;
            end
            else if (busy)
            begin
                if (wcnt != 2'h0)
                    wcnt <= wcnt - 2'h1;
                if (!irdy_n_i && !trdy_n_o)
                begin
                    beat <= beat + 1;
                    wcnt <= slow_i ? 2'h2 : 2'h0;
                end
                if (frame_n_i && (irdy_n_i || !trdy_n_o))
                    {busy, sel} <= 2'b00;
            end
        end
    end
endmodule // pcg_tgt_model

// file: tb/pcg_bridge_tb.sv
// Purpose : self-checking bench for the configuration cycle generator
// Assumes : 20 MHz clock, target model on the bus side
// Notes   : table rows first, then bursts, abort and reset
`timescale 1ns/1ps

// ============================================================
// testbench
module pcg_bridge_tb;
    typedef struct packed {logic mem; logic wr; logic [31:0] addr; logic [1:0] sz;
                           logic [31:0] wd; logic [31:0] ex; logic ck;} pcg_row_t;
    logic        sys_clk_i, rst_n_i, req_i, req_mem_i, req_wr_i, slow, abort;
    logic        busy_o, phase_ack_o, done_o, err_o, ad_oe_o, cbe_oe_o, frame_n_o, irdy_n_o, ctl_oe_o;
    logic        trdy_n_i, devsel_n_i, stop_n_i;
    logic [31:0] req_addr_i, req_wdata_i, rdata_o, ad_i, ad_o;
    logic [3:0]  req_len_i, cbe_n_o;
    logic [1:0]  req_size_i;
    int          errors, n_compared, n0, n_addr;
    logic [31:0] got [$];
    // mem, wr, address, size, write data, expected read, compare
    pcg_row_t rows [11] = '{'{1'b0, 1'b0, 32'h0CF8, 2'h2, 32'h0, 32'h0, 1'b1},
        '{1'b0, 1'b1, 32'h0CF8, 2'h2, 32'hFF125B1D, 32'h0, 1'b1},
        '{1'b0, 1'b0, 32'h0CF8, 2'h2, 32'h0, 32'h80125B1D, 1'b1},
        '{1'b0, 1'b0, 32'h0CFC, 2'h2, 32'h0, 32'hA5B75B1D, 1'b1},
        '{1'b0, 1'b1, 32'h0CF8, 2'h2, 32'h80005E04, 32'h80125B1D, 1'b1},
        '{1'b0, 1'b0, 32'h0CFC, 2'h2, 32'h0, 32'hA5E50604, 1'b1},
        '{1'b0, 1'b1, 32'h0CFE, 2'h0, 32'h00AB0000, 32'h0, 1'b0},
        '{1'b1, 1'b0, 32'h12345679, 2'h2, 32'h0, 32'hB7915678, 1'b1},
        '{1'b0, 1'b1, 32'h0CF8, 2'h2, 32'h00005E04, 32'h80005E04, 1'b1},
        '{1'b0, 1'b0, 32'h0CFC, 2'h2, 32'h0, 32'hA5A50CFC, 1'b1},
        '{1'b0, 1'b0, 32'h0CF8, 2'h1, 32'h0, 32'hA5A50CF8, 1'b1}};

    pcg_bridge pcg_bridge_i (.sys_clk_i, .rst_n_i, .req_i, .req_mem_i, .req_wr_i, .req_addr_i, .req_size_i,
        .req_len_i, .req_wdata_i, .busy_o, .phase_ack_o, .done_o, .err_o, .rdata_o, .ad_i, .ad_o, .ad_oe_o,
        .cbe_n_o, .cbe_oe_o, .frame_n_o, .irdy_n_o, .ctl_oe_o, .trdy_n_i, .devsel_n_i, .stop_n_i);
    pcg_tgt_model pcg_tgt_model_i (.clk_i(sys_clk_i), .rst_n_i, .slow_i(slow), .abort_i(abort), .ad_o_i(ad_o),
        .ad_oe_i(ad_oe_o), .cbe_n_i(cbe_n_o), .frame_n_i(frame_n_o), .irdy_n_i(irdy_n_o), .bus_o(ad_i),
        .trdy_n_o(trdy_n_i), .devsel_n_o(devsel_n_i), .stop_n_o(stop_n_i), .n_addr_o(n_addr));

    // one request, wait for done, keep read data of every phase
    task automatic do_req(input logic mem, input logic wr, input logic [31:0] a, input logic [1:0] sz,
                          input logic [3:0] len, input logic [31:0] wd);
        int n;
        n = 0;
        got.delete();
        @(posedge sys_clk_i);
        {req_i, req_mem_i, req_wr_i} <= {1'b1, mem, wr};
        {req_addr_i, req_size_i, req_len_i, req_wdata_i} <= {a, sz, len, wd};
        @(posedge sys_clk_i);
        req_i <= 1'b0;
        #1;
        while (done_o !== 1'b1 && n < 60)
        begin
            @(posedge sys_clk_i);
            #1;
            if (phase_ack_o === 1'b1)
                got.push_back(rdata_o);
            n++;
        end
        if (n >= 60)
            chk(32'h0, 32'h1);
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            errors++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic final_report;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // clock
    initial
    begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    // watchdog
    initial
    begin
        repeat (4000) @(posedge sys_clk_i);
        errors++;
        final_report;
    end

    // main sequence
    initial
    begin
        {errors, n_compared} = 64'h0;
        {rst_n_i, req_i, req_mem_i, req_wr_i, slow, abort} = 6'h0;
        {req_addr_i, req_size_i, req_len_i, req_wdata_i} = 70'h0;
        repeat (8) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 11; i++)
        begin
            do_req(rows[i].mem, rows[i].wr, rows[i].addr, rows[i].sz, 4'h0, rows[i].wd);
            if (rows[i].ck)
                chk(rdata_o, rows[i].ex);
            chk({31'h0, err_o}, 32'h0);
            $display("row %0d done", i);
        end
        for (int s = 0; s < 2; s++)
        begin
            slow <= s[0];
            n0 = n_addr;
            do_req(1'b1, 1'b0, 32'h20000000, 2'h2, 4'h3, 32'h0);
            chk(n_addr - n0, 32'h1);
            chk(got.size(), 32'h4);
            foreach (got[k])
                chk(got[k], (32'h20000000 + k * 4) ^ 32'hA5A50000);
            $display("burst test %0d done", s);
        end
        abort <= 1'b1;
        do_req(1'b0, 1'b0, 32'h0CFC, 2'h2, 4'h0, 32'h0);
        chk(rdata_o, 32'hFFFFFFFF);
        chk({31'h0, err_o}, 32'h1);
        abort <= 1'b0;
        $display("abort test done");
        @(posedge sys_clk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        do_req(1'b0, 1'b0, 32'h0CF8, 2'h2, 4'h0, 32'h0);
        chk(rdata_o, 32'h0);
        $display("reset test done");
        final_report;
    end
endmodule // pcg_bridge_tb
